// *** hdl/return_stack_pointer.sv ***
// return address stack with pointer, sticky flags and AXI4-Lite registers
`timescale 1ns/10ps
module return_stack_pointer
    import rsp_pkg::*;
(
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic por_n,
    // core call and return side
    input wire logic call_push,
    input wire logic ret_pop,
    input wire logic sw_push,
    input wire logic sw_pop,
    input wire logic [PC_W-1:0] pc_in,
    output logic [PC_W-1:0] ret_pc,
    output logic ret_valid,
    output logic overflow_reset,
    output logic [PC_W-1:0] top_entry,
    // axi4-lite write
    input wire logic [7:0] s_awaddr,
    input wire logic s_awvalid,
    output logic s_awready,
    input wire logic [31:0] s_wdata,
    input wire logic [3:0] s_wstrb,
    input wire logic s_wvalid,
    output logic s_wready,
    output logic [1:0] s_bresp,
    output logic s_bvalid,
    input wire logic s_bready,
    // axi4-lite read
    input wire logic [7:0] s_araddr,
    input wire logic s_arvalid,
    output logic s_arready,
    output logic [31:0] s_rdata,
    output logic [1:0] s_rresp,
    output logic s_rvalid,
    input wire logic s_rready
);
    typedef struct packed {
        logic [SP_W-1:0] sp;
        logic full;
        logic unf;
        logic ovr_en;
        logic [PC_W-1:0] ret_pc;
        logic ret_valid;
        logic ovr_rst;
        logic [7:0] aw_addr;
        logic aw_have;
        logic [31:0] w_data;
        logic [3:0] w_strb;
        logic w_have;
        bus_state_t wst;
        logic [1:0] bresp;
        bus_state_t rst;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } state_t;

    state_t s_reg, s_next;
    logic [PC_W-1:0] stack_mem [DEPTH];
    logic mem_we;
    logic [SP_W-1:0] mem_addr;
    logic [PC_W-1:0] mem_data;

    function automatic logic addr_known(input logic [7:0] a);
        if (a == ADDR_STATUS) begin
            return 1'b1;
        end else if (a == ADDR_TOP_LOW || a == ADDR_TOP_HIGH) begin
            return 1'b1;
        end else if (a == ADDR_TOP_UPPER || a == ADDR_CONFIG) begin
            return 1'b1;
        end else begin
            return 1'b0;
        end
    endfunction

    function automatic logic [7:0] status_byte(input state_t s);
        logic [7:0] b;
        b = 8'h00;
        b[FULL_BIT] = s.full; // [R16]
        b[UNF_BIT] = s.unf;
        b[SP_W-1:0] = s.sp;
        return b;
    endfunction

    logic push_any, pop_any, do_write;
    logic [PC_W-1:0] top_now;

    assign top_now = stack_mem[s_reg.sp];
    assign push_any = call_push | sw_push;
    assign pop_any = ret_pop | sw_pop;
    assign do_write = s_reg.aw_have && s_reg.w_have && s_reg.wst == BUS_IDLE;

    always_comb begin
        logic [PC_W-1:0] tw;
        tw = top_now;
        s_next = s_reg;
        mem_we = 1'b0;
        mem_addr = s_reg.sp;
        mem_data = pc_in;
        s_next.ret_valid = 1'b0;
        s_next.ovr_rst = 1'b0;

        // bus write capture, address and data in either order
        if (s_awvalid && !s_reg.aw_have) begin
            s_next.aw_addr = s_awaddr;
            s_next.aw_have = 1'b1;
        end
        if (s_wvalid && !s_reg.w_have) begin
            s_next.w_data = s_wdata;
            s_next.w_strb = s_wstrb;
            s_next.w_have = 1'b1;
        end
        if (do_write) begin
            s_next.aw_have = 1'b0;
            s_next.w_have = 1'b0;
            s_next.wst = BUS_RESP;
            s_next.bresp = addr_known(s_reg.aw_addr) ? RESP_OKAY : RESP_SLVERR;
            if (s_reg.w_strb[0]) begin
                if (s_reg.aw_addr == ADDR_STATUS) begin
                    s_next.sp = s_reg.w_data[SP_W-1:0]; // [R4]
                    // flags clear on zero only, never set by software
                    s_next.full = s_reg.full & s_reg.w_data[FULL_BIT]; // [R17]
                    s_next.unf = s_reg.unf & s_reg.w_data[UNF_BIT]; // [R17]
                end else if (s_reg.aw_addr == ADDR_TOP_LOW) begin
                    tw[7:0] = s_reg.w_data[7:0]; // [R15]
                    mem_we = 1'b1;
                end else if (s_reg.aw_addr == ADDR_TOP_HIGH) begin
                    tw[15:8] = s_reg.w_data[7:0]; // [R15]
                    mem_we = 1'b1;
                end else if (s_reg.aw_addr == ADDR_TOP_UPPER) begin
                    tw[PC_W-1:16] = s_reg.w_data[PC_W-17:0]; // [R15]
                    mem_we = 1'b1;
                end else if (s_reg.aw_addr == ADDR_CONFIG) begin
                    s_next.ovr_en = s_reg.w_data[0];
                end
            end
            mem_data = tw;
        end
        if (s_reg.wst == BUS_RESP && s_bready) begin
            s_next.wst = BUS_IDLE;
        end

        // stack operations; a core push or pop wins over a same-cycle pointer write
        if (push_any) begin
            if (s_reg.sp == SP_MAX) begin
                s_next.full = 1'b1; // [R9]
                s_next.sp = SP_MAX;
            end else if (s_reg.sp == SP_MAX - 5'h01) begin
                s_next.full = 1'b1; // [R5]
                if (s_reg.ovr_en) begin
                    mem_we = 1'b1;
                    mem_addr = SP_MAX;
                    mem_data = pc_in + PC_STEP; // [R7]
                    s_next.sp = SP_RESET; // [R8]
                    s_next.ovr_rst = 1'b1;
                end else begin
                    mem_we = 1'b1;
                    mem_addr = SP_MAX; // [R9]
                    mem_data = pc_in;
                    s_next.sp = SP_MAX;
                end
            end else begin
                mem_we = 1'b1;
                mem_addr = s_reg.sp + 5'h01; // [R2] [R13]
                mem_data = pc_in;
                s_next.sp = s_reg.sp + 5'h01; // [R1]
            end
        end else if (pop_any) begin
            s_next.ret_valid = ret_pop;
            if (s_reg.sp == SP_RESET) begin
                // underflow only vectors to zero; nothing else is reset
                s_next.ret_pc = '0; // [R10] [R12]
                s_next.unf = 1'b1; // [R10]
                // core pop outranks a same-cycle pointer write
                s_next.sp = SP_RESET;
            end else begin
                s_next.ret_pc = top_now;
                s_next.sp = s_reg.sp - 5'h01; // [R2] [R14]
            end
        end
        // hardware set wins over a same-cycle software clear
        if (push_any && s_reg.sp >= SP_MAX - 5'h01) begin
            s_next.full = 1'b1; // [R6]
        end
        if (pop_any && !push_any && s_reg.sp == SP_RESET) begin
            s_next.unf = 1'b1; // [R11]
        end

        // bus read
        if (s_reg.rst == BUS_IDLE && s_arvalid) begin
            s_next.rst = BUS_RESP;
            s_next.rresp = addr_known(s_araddr) ? RESP_OKAY : RESP_SLVERR;
            s_next.rdata = 32'h00000000;
            if (s_araddr == ADDR_STATUS) begin
                s_next.rdata[7:0] = status_byte(s_reg); // [R4]
            end else if (s_araddr == ADDR_TOP_LOW) begin
                s_next.rdata[7:0] = top_now[7:0]; // [R15]
            end else if (s_araddr == ADDR_TOP_HIGH) begin
                s_next.rdata[7:0] = top_now[15:8];
            end else if (s_araddr == ADDR_TOP_UPPER) begin
                s_next.rdata[PC_W-17:0] = top_now[PC_W-1:16];
            end else if (s_araddr == ADDR_CONFIG) begin
                s_next.rdata[0] = s_reg.ovr_en;
            end
        end else if (s_reg.rst == BUS_RESP && s_rready) begin
            s_next.rst = BUS_IDLE;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_reg.sp <= SP_RESET; // [R3]
            s_reg.ret_pc <= '0;
            s_reg.ret_valid <= 1'b0;
            s_reg.ovr_rst <= 1'b0;
            s_reg.aw_addr <= 8'h00;
            s_reg.aw_have <= 1'b0;
            s_reg.w_data <= 32'h00000000;
            s_reg.w_strb <= 4'h0;
            s_reg.w_have <= 1'b0;
            s_reg.wst <= BUS_IDLE;
            s_reg.bresp <= RESP_OKAY;
            s_reg.rst <= BUS_IDLE;
            s_reg.rdata <= 32'h00000000;
            s_reg.rresp <= RESP_OKAY;
            // flags and config survive ordinary reset; power-on clears the flags, and with aresetn low also loads config with CONFIG_RESET
            if (!por_n) begin
                s_reg.full <= 1'b0;
                s_reg.unf <= 1'b0;
                s_reg.ovr_en <= CONFIG_RESET;
            end else begin
                s_reg.full <= s_reg.full; // [R8]
                s_reg.unf <= s_reg.unf;
                s_reg.ovr_en <= s_reg.ovr_en;
            end
        end else if (!por_n) begin
            s_reg <= s_next;
            s_reg.full <= 1'b0;
            s_reg.unf <= 1'b0;
        end else begin
            s_reg <= s_next;
        end
    end

    always_ff @(posedge aclk) begin
        if (mem_we) begin
            stack_mem[mem_addr] <= mem_data;
        end
    end

    assign ret_pc = s_reg.ret_pc;
    assign ret_valid = s_reg.ret_valid;
    assign overflow_reset = s_reg.ovr_rst;
    assign top_entry = top_now;
    assign s_awready = !s_reg.aw_have;
    assign s_wready = !s_reg.w_have;
    assign s_bvalid = s_reg.wst == BUS_RESP;
    assign s_bresp = s_reg.bresp;
    assign s_arready = s_reg.rst == BUS_IDLE;
    assign s_rvalid = s_reg.rst == BUS_RESP;
    assign s_rdata = s_reg.rdata;
    assign s_rresp = s_reg.rresp;

    a_push_inc: assert property (@(posedge aclk) disable iff (!aresetn) // [R2]
        (call_push && !ret_pop && !sw_push && !sw_pop && s_reg.sp < 5'h1e && por_n)
        |=> s_reg.sp == $past(s_reg.sp) + 5'h01)
        else $error("pointer did not step up on push");
    a_unf_set: assert property (@(posedge aclk) disable iff (!aresetn) // [R10]
        (ret_pop && !push_any && s_reg.sp == 5'h00 && por_n)
        |=> s_reg.unf && s_reg.sp == 5'h00 && ret_pc == '0 && ret_valid)
        else $error("empty pop mishandled");
    a_full_sticky: assert property (@(posedge aclk) disable iff (!aresetn) // [R6]
        (s_reg.full && por_n) |=> s_reg.full || $past(do_write))
        else $error("full flag dropped without clear");
    a_ovr_reset: assert property (@(posedge aclk) disable iff (!aresetn) // [R7]
        (push_any && s_reg.ovr_en && s_reg.sp == 5'h1e && por_n)
        |=> overflow_reset && s_reg.full && s_reg.sp == 5'h00)
        else $error("overflow reset missing");
    a_saturate: assert property (@(posedge aclk) disable iff (!aresetn) // [R9]
        (push_any && !s_reg.ovr_en && s_reg.sp >= 5'h1e && por_n)
        |=> s_reg.sp == 5'h1f && s_reg.full)
        else $error("pointer not held at top");
    a_unf_sticky: assert property (@(posedge aclk) disable iff (!aresetn) // [R11]
        (s_reg.unf && por_n) |=> s_reg.unf || $past(do_write))
        else $error("underflow flag dropped without clear");
    a_pop_dec: assert property (@(posedge aclk) disable iff (!aresetn) // [R14]
        (sw_pop && !push_any && s_reg.sp != 5'h00 && por_n)
        |=> s_reg.sp == $past(s_reg.sp) - 5'h01)
        else $error("pointer did not step down on pop");
    a_no_sw_set: assert property (@(posedge aclk) disable iff (!aresetn) // [R17]
        (!s_reg.full && !push_any) |=> !s_reg.full)
        else $error("full flag set without a push");
    a_reset_zero: assert property (@(posedge aclk) // [R3]
        !aresetn |=> s_reg.sp == 5'h00)
        else $error("pointer not zero after reset");
    a_full_at_top: assert property (@(posedge aclk) disable iff (!aresetn) // [R5]
        (push_any && s_reg.sp == 5'h1e && por_n) |=> s_reg.full)
        else $error("full flag not set on last push");
    a_ovr_store: assert property (@(posedge aclk) disable iff (!aresetn) // [R7]
        (push_any && s_reg.ovr_en && s_reg.sp == 5'h1e)
        |=> stack_mem[5'h1f] == $past(pc_in) + PC_STEP)
        else $error("overflow push stored wrong value");
    a_sat_keep: assert property (@(posedge aclk) disable iff (!aresetn) // [R9]
        (push_any && !s_reg.ovr_en && s_reg.sp == 5'h1f && !do_write)
        |=> stack_mem[5'h1f] == $past(stack_mem[5'h1f]))
        else $error("top slot overwritten while saturated");
    a_sw_push_store: assert property (@(posedge aclk) disable iff (!aresetn) // [R13]
        (sw_push && !call_push && s_reg.sp < 5'h1e)
        |=> s_reg.sp == $past(s_reg.sp) + 5'h01 && top_entry == $past(pc_in))
        else $error("software push did not store pc");
    a_pop_return: assert property (@(posedge aclk) disable iff (!aresetn) // [R2]
        (ret_pop && !push_any && s_reg.sp != 5'h00)
        |=> ret_valid && ret_pc == $past(top_now) && s_reg.sp == $past(s_reg.sp) - 5'h01)
        else $error("return pop gave wrong address");
    a_ptr_write: assert property (@(posedge aclk) disable iff (!aresetn) // [R4]
        (do_write && s_reg.aw_addr == ADDR_STATUS && s_reg.w_strb[0] && !push_any && !pop_any)
        |=> s_reg.sp == $past(s_reg.w_data[SP_W-1:0]))
        else $error("pointer write not applied");
    a_unf_no_sw: assert property (@(posedge aclk) disable iff (!aresetn) // [R17]
        (!s_reg.unf && !pop_any) |=> !s_reg.unf)
        else $error("underflow flag set without a pop");
    a_unf_keeps_cfg: assert property (@(posedge aclk) disable iff (!aresetn) // [R12]
        (pop_any && !push_any && s_reg.sp == 5'h00 && !do_write)
        |=> s_reg.ovr_en == $past(s_reg.ovr_en) && !overflow_reset)
        else $error("underflow disturbed other state");
    a_pop_empty_sp: assert property (@(posedge aclk) disable iff (!aresetn) // [R10]
        (pop_any && !push_any && s_reg.sp == 5'h00 && por_n)
        |=> s_reg.sp == 5'h00 && s_reg.unf)
        else $error("empty pop moved the pointer");
    a_rst_keeps_full: assert property (@(posedge aclk) // [R8]
        (!aresetn && por_n && s_reg.full) |=> s_reg.full)
        else $error("full flag lost on plain reset");
    a_por_clears: assert property (@(posedge aclk) // [R6]
        !por_n |=> !s_reg.full && !s_reg.unf)
        else $error("flags not cleared by power-on reset");
    a_reset_bus: assert property (@(posedge aclk) // [R3]
        !aresetn |=> !s_bvalid && !s_rvalid && !ret_valid && !overflow_reset)
        else $error("outputs active after reset");
endmodule // return_stack_pointer

// *** include/rsp_pkg.sv ***
// constants and types for the return stack pointer block
// Behaviour
// [R1] pointer is five bits, range 0 to 31
// [R2] increment before push, decrement after pop
// [R3] reset forces pointer to zero
// [R4] software reads and writes the pointer
// [R5] full flag set after 31 pushes
// [R6] full flag sticky until software or POR
// [R7] overflow reset: store pc+2, flag, reset
// [R8] after overflow reset full stays, pointer zero
// [R9] no overflow reset: saturate at slot 31
// [R10] empty pop returns zero, sets underflow
// [R11] underflow flag sticky until software or POR
// [R12] underflow only vectors to zero, no reset
// [R13] software push: increment then store pc
// [R14] software pop: decrement, discard top
// [R15] top entry visible as three byte registers
// [R16] layout: full 7, underflow 6, pointer 4-0
// [R17] software can clear flags, never set them
package rsp_pkg;
    localparam int PC_W = 21;
    localparam int SP_W = 5;
    localparam int DEPTH = 32;
    localparam logic [SP_W-1:0] SP_MAX = 5'h1f;
    localparam logic [SP_W-1:0] SP_RESET = 5'h00;
    localparam logic [PC_W-1:0] PC_STEP = 21'h000002;
    localparam int FULL_BIT = 7;
    localparam int UNF_BIT = 6;
    localparam logic [7:0] ADDR_STATUS = 8'h00;
    localparam logic [7:0] ADDR_TOP_LOW = 8'h04;
    localparam logic [7:0] ADDR_TOP_HIGH = 8'h08;
    localparam logic [7:0] ADDR_TOP_UPPER = 8'h0c;
    localparam logic [7:0] ADDR_CONFIG = 8'h10;
    localparam logic CONFIG_RESET = 1'b1;
    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;
    typedef enum logic [1:0] {
        BUS_IDLE = 2'b01,
        BUS_RESP = 2'b10
    } bus_state_t;
endpackage

// *** verification/core_model.sv ***
// behavioural model of the core call and return side
`timescale 1ns/10ps
module core_model
    import rsp_pkg::*;
(
    // clock
    input wire logic aclk,
    // requests to the stack
    output logic call_push,
    output logic ret_pop,
    output logic sw_push,
    output logic sw_pop,
    output logic [PC_W-1:0] pc_in,
    // answers from the stack
    input wire logic [PC_W-1:0] ret_pc,
    input wire logic ret_valid,
    input wire logic overflow_reset
);
    logic [3:0] kick;
    assign {call_push, ret_pop, sw_push, sw_pop} = kick;
    initial begin
        kick = 4'h0;
        pc_in = '0;
    end
    // one pulse per op: 0 call, 1 return, 2 push, 3 pop
    task automatic op(input int k, input logic [PC_W-1:0] pc, output logic v,
                      output logic [PC_W-1:0] r, output logic o);
        kick <= 4'h8 >> k;
        pc_in <= pc;
        @(posedge aclk);
        kick <= 4'h0;
        // pc is only meaningful with a push, so do not leave it looking valid
        pc_in <= ~pc;
        #1;
        v = ret_valid;
        r = ret_pc;
        o = overflow_reset;
        @(posedge aclk);
    endtask
endmodule // core_model

// *** verification/return_stack_pointer_tb.sv ***
// self-checking bench for the return stack pointer
`timescale 1ns/10ps
module return_stack_pointer_tb
    import rsp_pkg::*;
;
    logic aclk, aresetn, por_n, call_push, ret_pop, sw_push, sw_pop, ret_valid, overflow_reset;
    logic [PC_W-1:0] pc_in, ret_pc, top_entry;
    logic [7:0] s_awaddr, s_araddr;
    logic [31:0] s_wdata, s_rdata, seed;
    logic [3:0] s_wstrb;
    logic [1:0] s_bresp, s_rresp;
    logic s_awvalid, s_awready, s_wvalid, s_wready, s_bvalid, s_bready;
    logic s_arvalid, s_arready, s_rvalid, s_rready;
    int err_total, checked, sp, full, unf, en, stk[32];
    return_stack_pointer return_stack_pointer_inst (.aclk, .aresetn, .por_n, .call_push, .ret_pop,
        .sw_push, .sw_pop, .pc_in, .ret_pc, .ret_valid, .overflow_reset, .top_entry, .s_awaddr,
        .s_awvalid, .s_awready, .s_wdata, .s_wstrb, .s_wvalid, .s_wready, .s_bresp, .s_bvalid,
        .s_bready, .s_araddr, .s_arvalid, .s_arready, .s_rdata, .s_rresp, .s_rvalid, .s_rready);
    core_model core_model_inst (.aclk, .call_push, .ret_pop, .sw_push, .sw_pop, .pc_in, .ret_pc,
        .ret_valid, .overflow_reset);
    initial begin
        aclk = 1'b0;
        forever #2 aclk = ~aclk;
    end
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic print_verdict;
        if (err_total == 0 && checked > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    task automatic fail_out;
        err_total++;
        print_verdict();
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string nm);
        checked++;
        if (got !== exp) begin
            err_total++;
            $display("unexpected %s: expected %h, seen %h", nm, exp, got);
        end
    endtask
    // ready is sampled mid-cycle since it is combinational and settles before the edge
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] st,
                          input logic [1:0] er);
        logic ad, wd;
        int n;
        s_awaddr <= a;
        s_wdata <= d;
        s_wstrb <= st;
        s_awvalid <= 1'b1;
        s_wvalid <= 1'b1;
        for (n = 0; n < 40; n++) begin
            @(negedge aclk);
            if (s_bvalid === 1'b1) break;
            ad = s_awvalid & s_awready;
            wd = s_wvalid & s_wready;
            @(posedge aclk);
            if (ad) s_awvalid <= 1'b0;
            if (wd) s_wvalid <= 1'b0;
        end
        if (n == 40) fail_out();
        chk(32'(s_bresp), 32'(er), "bresp");
        @(posedge aclk);
    endtask
    task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        logic ah;
        int n;
        s_araddr <= a;
        s_arvalid <= 1'b1;
        for (n = 0; n < 40; n++) begin
            @(negedge aclk);
            if (s_rvalid === 1'b1) break;
            ah = s_arvalid & s_arready;
            @(posedge aclk);
            if (ah) s_arvalid <= 1'b0;
        end
        if (n == 40) fail_out();
        d = s_rdata;
        r = s_rresp;
        @(posedge aclk);
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] e, input string nm);
        logic [31:0] d;
        logic [1:0] r;
        axi_rd(a, d, r);
        chk(d, e, nm);
        chk(32'(r), 32'(RESP_OKAY), "rresp");
    endtask
    task automatic state_chk;
        rd_chk(ADDR_STATUS, 32'(full * 128 + unf * 64 + sp), "status");
        if (sp > 0) chk(32'(top_entry), 32'(stk[sp]), "top_entry");
    endtask
    task automatic sw_status(input logic [7:0] v);
        axi_wr(ADDR_STATUS, {24'h0, v}, 4'hf, RESP_OKAY);
        sp = int'(v[4:0]);
        full = full & int'(v[7]);
        unf = unf & int'(v[6]);
    endtask
    task automatic do_op(input int k, input logic [PC_W-1:0] pc);
        int ev, er, eo;
        logic v, o;
        logic [PC_W-1:0] r, nx;
        ev = 0;
        er = 0;
        eo = 0;
        nx = pc + PC_STEP;
        if (k == 0 || k == 2) begin
            if (sp < 31) begin
                sp++;
                stk[sp] = pc;
                if (sp == 31) begin
                    full = 1;
                    if (en == 1) begin
                        stk[31] = nx;
                        sp = 0;
                        eo = 1;
                    end
                end
            end else full = 1;
        end else if (k == 1) begin
            ev = 1;
            if (sp == 0) unf = 1;
            else begin
                er = stk[sp];
                sp--;
            end
        end else if (sp > 0) sp--;
        core_model_inst.op(k, pc, v, r, o);
        chk(32'(v), 32'(ev), "ret_valid");
        if (ev == 1) chk(32'(r), 32'(er), "ret_pc");
        chk(32'(o), 32'(eo), "overflow_reset");
        state_chk();
    endtask
    initial begin
        int i, k;
        logic [31:0] d;
        logic [1:0] rs;
        {aresetn, por_n, s_awvalid, s_wvalid, s_arvalid} = 5'h0;
        {s_awaddr, s_araddr, s_wdata, s_wstrb} = '0;
        {s_bready, s_rready} = 2'h3;
        {err_total, checked, sp, full, unf} = '0;
        en = 1;
        seed = 32'h1754;
        repeat (20) @(posedge aclk);
        aresetn <= 1'b1;
        por_n <= 1'b1;
        @(posedge aclk);
        state_chk();
        rd_chk(ADDR_CONFIG, 32'h1, "config");
        axi_rd(8'h14, d, rs);
        chk(32'(rs), 32'(RESP_SLVERR), "rresp");
        axi_wr(8'h14, 32'h0, 4'hf, RESP_SLVERR);
        for (i = 0; i < 200; i++) begin
            seed = lfsr(seed);
            k = int'(seed[1:0]);
            if (k == 2 && sp >= 30) k = 0;
            if (k == 3 && sp == 0) k = 1;
            do_op(k, seed[PC_W+1:2]);
        end
        sw_status(8'h00);
        for (i = 1; i <= 31; i++) do_op(0, PC_W'(i * 16));
        sw_status(8'h9f);
        state_chk();
        axi_wr(ADDR_TOP_LOW, 32'h5a, 4'hf, RESP_OKAY);
        axi_wr(ADDR_TOP_HIGH, 32'ha5, 4'hf, RESP_OKAY);
        axi_wr(ADDR_TOP_UPPER, 32'h13, 4'hf, RESP_OKAY);
        stk[31] = 32'h13a55a;
        state_chk();
        rd_chk(ADDR_TOP_HIGH, 32'ha5, "top_high");
        // a write without byte 0 enabled must change nothing
        axi_wr(ADDR_STATUS, 32'h0, 4'h0, RESP_OKAY);
        state_chk();
        axi_wr(ADDR_CONFIG, 32'h0, 4'hf, RESP_OKAY);
        en = 0;
        sw_status(8'he3);
        state_chk();
        sw_status(8'h00);
        for (i = 1; i <= 32; i++) do_op(i < 20 ? 2 : 0, PC_W'(i * 32));
        sw_status(8'h80);
        do_op(1, '0);
        rd_chk(ADDR_CONFIG, 32'h0, "config");
        aresetn <= 1'b0;
        @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        sp = 0;
        state_chk();
        aresetn <= 1'b0;
        por_n <= 1'b0;
        @(posedge aclk);
        aresetn <= 1'b1;
        por_n <= 1'b1;
        @(posedge aclk);
        {full, unf} = '0;
        state_chk();
        rd_chk(ADDR_CONFIG, 32'h1, "config");
        print_verdict();
    end
endmodule // return_stack_pointer_tb
